// ==== hw/wdtu_pkg.sv ====
// wdtu_pkg: constants and carrier types of the watchdog timer unit.
// assumes a single 20 MHz core clock and software commands that arrive
// as one-cycle strobes synchronous to that clock.
package wdtu_pkg;

	// core clock rate, kept for reference; no cycle count is derived from it
	localparam int unsigned CORE_CLK_HZ = 20_000_000;

	// counter geometry
	localparam int unsigned CNT_W = 16;
	localparam logic [15:0] CNT_ALL_ONES = 16'hffff;

	// the two fixed prescaler ratios and the prescaler width
	localparam int unsigned DIV_FAST = 256;
	localparam int unsigned DIV_SLOW = 16384;
	localparam int unsigned PRESC_W = 14;

	// reset defaults: fast ratio and reload 0xff00 give 256 ticks of
	// 256 clocks, i.e. 65536 clocks, about 6.5 ms at 10 MHz
	localparam logic RST_DIV_SLOW = 1'b0;
	localparam logic [15:0] RST_RELOAD = 16'hff00;

	// documented interval figures (for reference only; the bench does not read them)
	localparam int unsigned DEFAULT_INTERVAL_US = 6500;
	localparam int unsigned DEFAULT_REF_CLK_HZ = 10_000_000;
	localparam int unsigned SPAN_REF_CLK_HZ = 80_000_000;
	localparam int unsigned SPAN_MAX_MS = 13400;

	// watchdog sequence states
	typedef enum logic [1:0] {
		WDTU_ST_RUN = 2'b00,
		WDTU_ST_WARN = 2'b01,
		WDTU_ST_FIRED = 2'b10
	} wdtu_state_t;

	// one-cycle command strobes from the cpu
	typedef struct packed {
		logic service;
		logic disable_supervisor_instr;
		logic enable_supervisor_instr;
		logic cfg_write;
	} wdtu_cmd_t;

	// configuration word taken on cfg_write
	typedef struct packed {
		logic div_slow;
		logic [15:0] supervisor_reload_value;
	} wdtu_cfg_t;

endpackage

// ==== hw/wdtu_prescaler.sv ====
// wdtu_prescaler: divides the core clock by one of two fixed ratios and
// gives a one-cycle tick enable to the watchdog counter.
// assumes clear and run are synchronous levels from the parent.
`timescale 1ns/1ps
module wdtu_prescaler #(
	parameter int unsigned FAST_RATIO = wdtu_pkg::DIV_FAST,
	parameter int unsigned SLOW_RATIO = wdtu_pkg::DIV_SLOW
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic clear,
	input wire logic div_slow,
	output logic tick
);
	localparam logic [13:0] FAST_LAST = 14'(FAST_RATIO - 1);
	localparam logic [13:0] SLOW_LAST = 14'(SLOW_RATIO - 1);

	logic [wdtu_pkg::PRESC_W-1:0] div_reg;
	logic [wdtu_pkg::PRESC_W-1:0] last;

	// terminal count of the selected ratio
	assign last = div_slow ? SLOW_LAST : FAST_LAST;

	// divider: clear wins over counting so a service restarts a full tick
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
			tick <= 1'b0;
		end else if (clear) begin
			div_reg <= '0; // see (RQ7)
			tick <= 1'b0;
		end else if (run) begin
			tick <= (div_reg >= last); // see (RQ5)
			div_reg <= (div_reg >= last) ? '0 : div_reg + 14'h1;
		end else begin
			tick <= 1'b0;
		end
	end
endmodule // wdtu_prescaler

// ==== hw/wdtu_top.sv ====
// wdtu_top: fail-safe watchdog timer unit with prewarning and reset request.
// assumes cpu commands are one-cycle strobes on core_clk and that rst_n is
// the application reset, which also clears a pending reset request.
//
// Summary of operation
// (RQ1) watchdog runs enabled straight after reset
// (RQ2) disable and enable commands act any time
// (RQ3) software services before each counter overflow
// (RQ4) overflow gives prewarning, then reset request
// (RQ5) 16-bit counter, prescaler divides 16384 or 256
// (RQ6) every load takes the programmable reload value
// (RQ7) service reloads counter and clears prescaler
// (RQ8) defaults give 6.5 ms at 10 MHz
// (RQ9) interval spans 3.2 us to 13.4 s
// (RQ10) counts up, overflow on wrap past all-ones
`timescale 1ns/1ps
module wdtu_top #(
	parameter int unsigned FAST_RATIO = wdtu_pkg::DIV_FAST,
	parameter int unsigned SLOW_RATIO = wdtu_pkg::DIV_SLOW
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire wdtu_pkg::wdtu_cmd_t cmd,
	input wire wdtu_pkg::wdtu_cfg_t cfg,
	output logic prewarn_irq,
	output logic reset_req,
	output logic wd_enabled,
	output logic wd_warning,
	output logic [15:0] wd_count
);
	wdtu_pkg::wdtu_state_t state_reg;
	wdtu_pkg::wdtu_state_t state_next;
	logic [15:0] reload_reg;
	logic div_slow_reg;
	logic enabled_next;
	logic tick;
	logic overflow;
	logic service_ok;
	logic presc_clear;
	logic run;

	// the counter only advances while enabled and before the reset fires
	assign run = wd_enabled && (state_reg != wdtu_pkg::WDTU_ST_FIRED);

	// wrap past all-ones on a tick is the overflow event
	assign overflow = run && tick &&
		(wd_count == wdtu_pkg::CNT_ALL_ONES); // see (RQ10)

	// a service during the prewarning phase cannot undo the failure
	assign service_ok = cmd.service &&
		(state_reg == wdtu_pkg::WDTU_ST_RUN);

	// prescaler restarts on every accepted service and on every overflow
	assign presc_clear = service_ok || overflow; // see (RQ7)

	wdtu_prescaler #(
		.FAST_RATIO(FAST_RATIO),
		.SLOW_RATIO(SLOW_RATIO)
	) u_presc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(run),
		.clear(presc_clear),
		.div_slow(div_slow_reg),
		.tick(tick)
	);

	// configuration: reset defaults give the documented power-up interval
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_reg <= wdtu_pkg::RST_RELOAD; // see (RQ8)
			div_slow_reg <= wdtu_pkg::RST_DIV_SLOW; // see (RQ8)
		end else if (cmd.cfg_write) begin
			// any reload value and either ratio are allowed, see (RQ9)
			reload_reg <= cfg.supervisor_reload_value; // see (RQ6)
			div_slow_reg <= cfg.div_slow; // see (RQ5)
		end
	end

	// enable wins when both commands come together: fail-safe choice
	always_comb begin
		enabled_next = wd_enabled;
		if (cmd.disable_supervisor_instr) begin
			enabled_next = 1'b0; // see (RQ2)
		end
		if (cmd.enable_supervisor_instr) begin
			enabled_next = 1'b1; // see (RQ2)
		end
	end

	// enable flag comes up set with no software action
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_enabled <= 1'b1; // see (RQ1)
		end else begin
			wd_enabled <= enabled_next;
		end
	end

	// 16-bit up-counter; service and overflow reload it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_count <= wdtu_pkg::RST_RELOAD; // see (RQ1)
		end else if (service_ok) begin
			wd_count <= reload_reg; // see (RQ7)
		end else if (overflow) begin
			// the prewarning phase is timed by a second reload interval
			wd_count <= reload_reg; // see (RQ6)
		end else if (run && tick) begin
			wd_count <= wd_count + 16'h1; // see (RQ10)
		end
	end

	// sequence: first overflow warns, second one fires the reset request
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			wdtu_pkg::WDTU_ST_RUN: begin
				if (overflow) begin
					state_next = wdtu_pkg::WDTU_ST_WARN; // see (RQ4)
				end
			end
			wdtu_pkg::WDTU_ST_WARN: begin
				if (overflow) begin
					state_next = wdtu_pkg::WDTU_ST_FIRED; // see (RQ4)
				end
			end
			wdtu_pkg::WDTU_ST_FIRED: begin
				state_next = wdtu_pkg::WDTU_ST_FIRED;
			end
			default: begin
				state_next = wdtu_pkg::WDTU_ST_FIRED;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= wdtu_pkg::WDTU_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// prewarning is a one-cycle pulse on the first overflow
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prewarn_irq <= 1'b0;
		end else begin
			prewarn_irq <= overflow &&
				(state_reg == wdtu_pkg::WDTU_ST_RUN); // see (RQ4)
		end
	end

	// reset request holds until the application reset clears it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_req <= 1'b0;
		end else if (overflow && (state_reg == wdtu_pkg::WDTU_ST_WARN)) begin
			reset_req <= 1'b1; // see (RQ4)
		end
	end

	// warning status so software knows a service is now too late
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_warning <= 1'b0;
		end else begin
			wd_warning <= (state_next == wdtu_pkg::WDTU_ST_WARN);
		end
	end

	// a timely service keeps the sequence in the run state; see (RQ3)
endmodule // wdtu_top

// ==== tb/wdtu_assertions.sv ====
// wdtu_chk: port-level checker for the watchdog unit.
// assumes it is bound to wdtu_top and sees only that module's ports.
`timescale 1ns/1ps
module wdtu_chk #(
	parameter int unsigned FAST_RATIO = wdtu_pkg::DIV_FAST,
	parameter int unsigned SLOW_RATIO = wdtu_pkg::DIV_SLOW
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire wdtu_pkg::wdtu_cmd_t cmd,
	input wire wdtu_pkg::wdtu_cfg_t cfg,
	input wire logic prewarn_irq,
	input wire logic reset_req,
	input wire logic wd_enabled,
	input wire logic wd_warning,
	input wire logic [15:0] wd_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] rel_reg;
	// shadow of the reload value, so a service can be judged
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) rel_reg <= wdtu_pkg::RST_RELOAD;
		else if (cmd.cfg_write) rel_reg <= cfg.supervisor_reload_value;
	end
	// a same-cycle config write is excluded: it would move the shadow
	property p_svc; cmd.service && !cmd.cfg_write && wd_enabled &&
		!cmd.disable_supervisor_instr && !wd_warning && !reset_req
		|=> wd_count == rel_reg; endproperty
	property p_dis; cmd.disable_supervisor_instr &&
		!cmd.enable_supervisor_instr |=> !wd_enabled; endproperty
	property p_en; cmd.enable_supervisor_instr |=> wd_enabled; endproperty
	property p_frz; !wd_enabled && !cmd.service &&
		!cmd.enable_supervisor_instr |=> $stable(wd_count); endproperty
	property p_up; $changed(wd_count) && !$past(cmd.service) &&
		$past(wd_count) != 16'hffff |-> wd_count == $past(wd_count) + 16'h1;
	endproperty
	property p_pulse; prewarn_irq |=> !prewarn_irq; endproperty
	property p_order; $rose(reset_req) |->
		$past(wd_warning) || $past(wd_warning, 2); endproperty
	property p_hold; reset_req |=> reset_req; endproperty
	a_svc: assert property (p_svc) else $error("no reload");
	a_dis: assert property (p_dis) else $error("not off");
	a_en: assert property (p_en) else $error("not on");
	a_frz: assert property (p_frz) else $error("ran while off");
	a_up: assert property (p_up) else $error("bad step");
	a_pulse: assert property (p_pulse) else $error("long irq");
	a_order: assert property (p_order) else $error("no warning");
	a_hold: assert property (p_hold) else $error("req dropped");
	c_irq: cover property (prewarn_irq);
	c_req: cover property ($rose(reset_req));
	c_svc: cover property (cmd.service && wd_enabled);
endmodule // wdtu_chk
bind wdtu_top wdtu_chk #(.FAST_RATIO(FAST_RATIO), .SLOW_RATIO(SLOW_RATIO))
	chk_u (.core_clk, .rst_n, .cmd, .cfg, .prewarn_irq, .reset_req,
	.wd_enabled, .wd_warning, .wd_count);

// ==== tb/wdtu_cpu_model.sv ====
// wdtu_cpu_model: software side of the watchdog, issues command strobes.
// assumes the bench calls its tasks; it drives on falling edges only.
`timescale 1ns/1ps
module wdtu_cpu_model (
	input wire logic core_clk,
	output wdtu_pkg::wdtu_cmd_t cmd,
	output wdtu_pkg::wdtu_cfg_t cfg
);
	initial {cmd, cfg} = '0;
	// one-cycle strobe spanning exactly one rising edge
	task automatic pulse(input wdtu_pkg::wdtu_cmd_t c);
		@(negedge core_clk);
		cmd = c;
		@(negedge core_clk);
		cmd = '0;
	endtask
	// new ratio and reload value, taken with the write strobe
	task automatic setup(input logic slow, input logic [15:0] rel);
		cfg = {slow, rel};
		pulse(4'b0001);
	endtask
	// gap must stay below one interval or the watchdog fires
	task automatic keep_alive(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(negedge core_clk);
			pulse(4'b1000);
		end
	endtask
endmodule // wdtu_cpu_model

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the watchdog unit with short ratios.
// assumes the cpu model beside it and the checker bound to the design.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	wdtu_pkg::wdtu_cmd_t cmd;
	wdtu_pkg::wdtu_cfg_t cfg;
	logic prewarn_irq, reset_req, wd_enabled, wd_warning;
	logic [15:0] wd_count;
	logic irq_seen = 1'b0;
	int miscompares = 0;
	int cmp_count = 0;
	always #25 core_clk = ~core_clk;
	// the prewarning lasts one cycle, so keep a sticky copy
	always @(posedge core_clk) if (prewarn_irq === 1'b1) irq_seen <= 1'b1;
	wdtu_cpu_model cpu_u (.core_clk, .cmd, .cfg);
	wdtu_top #(.FAST_RATIO(4), .SLOW_RATIO(8)) dut_u (.core_clk, .rst_n,
		.cmd, .cfg, .prewarn_irq, .reset_req, .wd_enabled, .wd_warning,
		.wd_count);
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// bounded wait on the irq copy (req 0) or the reset request (req 1);
	// running out counts as a mismatch
	task automatic wait_flag(input bit req, input int n);
		for (int i = 0; i < n && (req ? reset_req : irq_seen) !== 1'b1;
			i++) @(negedge core_clk);
		if ((req ? reset_req : irq_seen) !== 1'b1) begin
			miscompares++;
			close_out();
		end
	endtask
	// defaults straight after reset, then the first step
	task automatic t_reset();
		`CHK("on", 1'b1, wd_enabled)
		`CHK("count", 16'hff00, wd_count)
		repeat (4) @(negedge core_clk);
		`CHK("pre", 16'hff00, wd_count)
		@(negedge core_clk);
		`CHK("step", 16'hff01, wd_count)
	endtask
	// slow ratio, then a service restarts a full prescaler period
	task automatic t_service();
		cpu_u.setup(1'b1, 16'hfff0);
		cpu_u.pulse(4'b1000);
		`CHK("reload", 16'hfff0, wd_count)
		repeat (6) @(negedge core_clk);
		`CHK("held", 16'hfff0, wd_count)
		repeat (2) @(negedge core_clk);
		`CHK("last", 16'hfff0, wd_count)
		@(negedge core_clk);
		`CHK("tick", 16'hfff1, wd_count)
	endtask
	// disable freezes the count; enable wins over disable
	task automatic t_disable();
		logic [15:0] held;
		cpu_u.pulse(4'b0100);
		held = wd_count;
		`CHK("off", 1'b0, wd_enabled)
		repeat (40) @(negedge core_clk);
		`CHK("frozen", held, wd_count)
		cpu_u.pulse(4'b0110);
		`CHK("on", 1'b1, wd_enabled)
		// the prescaler kept its phase while off, so the step comes early
		repeat (5) @(negedge core_clk);
		`CHK("resume", held, wd_count)
		@(negedge core_clk);
		`CHK("resumed", held + 16'h1, wd_count)
	endtask
	// fast ratio and a new reload value, taken by the next service
	task automatic t_reload();
		cpu_u.setup(1'b0, 16'hfffd);
		cpu_u.pulse(4'b1000);
		`CHK("reload2", 16'hfffd, wd_count)
		repeat (4) @(negedge core_clk);
		`CHK("wait2", 16'hfffd, wd_count)
		@(negedge core_clk);
		`CHK("step2", 16'hfffe, wd_count)
	endtask
	// unserviced: warning first, a late service is ignored, then reset
	task automatic t_overflow();
		wait_flag(1'b0, 300);
		`CHK("early", 1'b0, reset_req)
		`CHK("warn", 1'b1, wd_warning)
		cpu_u.pulse(4'b1000);
		// an accepted service would have held the count at the reload value
		repeat (2) @(negedge core_clk);
		`CHK("late", 16'hfffe, wd_count)
		wait_flag(1'b1, 300);
		repeat (20) @(negedge core_clk);
		`CHK("req", 1'b1, reset_req)
	endtask
	initial begin
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		t_reset();
		t_service();
		t_disable();
		irq_seen = 1'b0;
		cpu_u.keep_alive(4, 60);
		`CHK("quiet", 1'b0, irq_seen)
		t_reload();
		t_overflow();
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		`CHK("clear", 1'b0, reset_req)
		`CHK("count", 16'hff00, wd_count)
		t_reset();
		close_out();
	end
endmodule // tb_top
